// [rtl/fcws_pkg.sv]
// fcws_pkg: constants and types for the fieldbus command word sequencer
// assumes: single clock domain, synchronous active-high reset
package fcws_pkg;

    localparam int CMD_WIDTH = 16;
    localparam logic [15:0] CMD_RESET = 16'h0005;
    localparam logic [15:0] STATUS_RESET = 16'h0001;

    localparam int BIT_SWITCH_ON_EN = 0;
    localparam int BIT_BREAKER_EN = 1;
    localparam int BIT_QSTOP_N = 2;
    localparam int BIT_START = 3;
    localparam int BIT_PRECHARGE = 4;
    localparam int BIT_EVENT_RESET = 7;
    localparam int BIT_DATA_VALID = 10;

    localparam logic START_MODE_LEVEL = 1'b0;
    localparam logic START_MODE_EDGE = 1'b1;

    localparam int STAT_OFF = 0;
    localparam int STAT_READY = 1;
    localparam int STAT_SWITCHED_ON = 2;
    localparam int STAT_OPERATING = 3;
    localparam int STAT_QSTOP = 4;
    localparam int STAT_FAULT = 5;
    localparam int STAT_PRECHARGING = 6;
    localparam int STAT_BREAKER = 7;
    localparam int STAT_REMOTE = 8;

    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_READY = 4'h2,
        ST_SWITCHED_ON = 4'h4,
        ST_OPERATING = 4'h8
    } fcws_state_type;

    typedef struct packed {
        logic switch_on_en;
        logic breaker_en;
        logic qstop_n;
        logic start;
        logic precharge;
        logic event_reset;
    } fcws_cmd_type;

    typedef struct packed {
        fcws_state_type state;
        logic [15:0] cmd_word;
        logic start_q;
        logic reset_q;
        logic edge_armed;
        logic charging;
        logic breaker_close;
        logic modulate;
        logic fault_reset_req;
        logic quick_stop_evt;
        logic [15:0] status_word;
    } fcws_regs_type;

endpackage

// [rtl/fcws_sequencer.sv]
// fcws_sequencer: interprets the fieldbus command word and sequences
// off / ready / switched on / operating; status word always refreshed.
// assumes: command word is written by the fieldbus interface with a
// one-cycle write strobe; fault, inhibit and charge-done come from the
// surrounding converter logic, all synchronous to i_sys_clk.
`timescale 1ns/10ps

// Contract
// - status word is refreshed every cycle whatever control place is active.
// - start mode setting is only 0 level or 1 edge; no pulse mode.
// - level mode: start bit high is the start request.
// - level mode: start bit low stops the converter.
// - level mode: start bit high when a fault clears starts at once.
// - edge mode: start needs rising edge of start bit, then it stays high.
// - edge mode: start bit already high at fault clear does not start.
// - switch-on enable or breaker enable low blocks any start.
// - transitions act only with data valid high and fieldbus in control.
// - four states: off, ready (no fault, no inhibit), switched on, operating.
// - switch-on enable low aborts charge, breaker close, run; opens breaker.
// - off-to-ready needs switch-on enable seen low first; low stops run.
// - breaker enable permits ready and closing; low opens, returns to off.
// - start low stops or aborts startup; start high launches or keeps run.
// - pre-charge begins only on a rising edge of the start bit.
// - edge refused while unable to start needs a fresh edge later.
// - application pre-charge: bit 4 starts/continues, low stops charging.
// - data valid low holds last accepted word; reset value is 0x5.
// - rising edge of bit 7 requests a reset of faults and warnings.
module fcws_sequencer (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_cmd_write,
    input wire logic [15:0] i_fieldbus_command_word,
    input wire logic i_fieldbus_active,
    input wire logic i_start_mode,
    input wire logic i_app_precharge,
    input wire logic i_fault_active,
    input wire logic i_inhibit,
    input wire logic i_charge_done,
    input wire logic i_main_breaker_closed,
    input wire logic i_main_breaker_own,
    output logic [15:0] o_status_word,
    output logic [3:0] o_state,
    output logic o_charging,
    output logic o_main_breaker_close,
    output logic o_modulate,
    output logic o_fault_reset_req,
    output logic o_quick_stop_evt
);

    fcws_pkg::fcws_regs_type r;
    fcws_pkg::fcws_regs_type next_r;

    function automatic fcws_pkg::fcws_cmd_type decode_cmd(
        input logic [15:0] w
    );
        fcws_pkg::fcws_cmd_type c;
        c.switch_on_en = w[fcws_pkg::BIT_SWITCH_ON_EN];
        c.breaker_en = w[fcws_pkg::BIT_BREAKER_EN];
        c.qstop_n = w[fcws_pkg::BIT_QSTOP_N];
        c.start = w[fcws_pkg::BIT_START];
        c.precharge = w[fcws_pkg::BIT_PRECHARGE];
        c.event_reset = w[fcws_pkg::BIT_EVENT_RESET];
        return c;
    endfunction

    function automatic logic enables_of(
        input fcws_pkg::fcws_cmd_type c
    );
        return c.switch_on_en & c.breaker_en;
    endfunction

    function automatic logic state_is(
        input fcws_pkg::fcws_state_type s,
        input fcws_pkg::fcws_state_type want
    );
        return s == want;
    endfunction

    function automatic logic start_request(
        input logic mode,
        input fcws_pkg::fcws_cmd_type c,
        input logic armed
    );
        logic req;
        // only 0 and 1 exist: the setting is one bit
        if (mode == fcws_pkg::START_MODE_LEVEL)
        begin
            req = c.start;
        end
        else
        begin
            req = c.start & armed;
        end
        return req;
    endfunction

    function automatic logic ready_allowed(
        input fcws_pkg::fcws_cmd_type c,
        input logic fault,
        input logic inhibit
    );
        // switch-on enable must be seen low first
        return !c.switch_on_en && c.breaker_en && !fault && !inhibit;
    endfunction

    function automatic logic drop_to_off(
        input fcws_pkg::fcws_cmd_type c,
        input logic fault
    );
        return !c.breaker_en || fault;
    endfunction

    function automatic logic step_down(
        input fcws_pkg::fcws_cmd_type c
    );
        return !c.switch_on_en || !c.start;
    endfunction

    function automatic fcws_pkg::fcws_state_type step_back(
        input fcws_pkg::fcws_state_type s
    );
        fcws_pkg::fcws_state_type b;
        case (s)
            fcws_pkg::ST_OPERATING:
            begin
                b = fcws_pkg::ST_SWITCHED_ON;
            end
            fcws_pkg::ST_SWITCHED_ON:
            begin
                b = fcws_pkg::ST_READY;
            end
            default:
            begin
                b = fcws_pkg::ST_OFF;
            end
        endcase
        return b;
    endfunction

    function automatic logic charge_next(
        input fcws_pkg::fcws_cmd_type c,
        input logic rise,
        input logic allow,
        input logic prev
    );
        logic on;
        on = prev;
        if (!prev)
        begin
            on = rise & c.switch_on_en & allow;
        end
        else if (!c.start || !c.switch_on_en || !allow)
        begin
            on = 1'b0;
        end
        return on;
    endfunction

    function automatic logic breaker_next(
        input fcws_pkg::fcws_cmd_type c,
        input fcws_pkg::fcws_state_type s,
        input logic own,
        input logic prev
    );
        logic close;
        close = prev;
        // closes after charging, opens on either enable low
        if (!enables_of(c) ||
            state_is(s, fcws_pkg::ST_OFF) ||
            state_is(s, fcws_pkg::ST_READY))
        begin
            close = 1'b0;
        end
        else if (own)
        begin
            close = 1'b1;
        end
        return close;
    endfunction

    function automatic logic [15:0] status_of(
        input fcws_pkg::fcws_state_type s,
        input logic qstop_n,
        input logic fault,
        input logic charging,
        input logic breaker,
        input logic active
    );
        logic [15:0] w;
        w = 16'h0000;
        w[fcws_pkg::STAT_OFF] = state_is(s, fcws_pkg::ST_OFF);
        w[fcws_pkg::STAT_READY] = state_is(s, fcws_pkg::ST_READY);
        w[fcws_pkg::STAT_SWITCHED_ON] =
            state_is(s, fcws_pkg::ST_SWITCHED_ON);
        w[fcws_pkg::STAT_OPERATING] = state_is(s, fcws_pkg::ST_OPERATING);
        w[fcws_pkg::STAT_QSTOP] = ~qstop_n;
        w[fcws_pkg::STAT_FAULT] = fault;
        w[fcws_pkg::STAT_PRECHARGING] = charging;
        w[fcws_pkg::STAT_BREAKER] = breaker;
        w[fcws_pkg::STAT_REMOTE] = active;
        return w;
    endfunction

    fcws_pkg::fcws_cmd_type cmd;
    logic start_rise;
    logic start_req;
    logic enables_ok;
    logic run_ok;
    logic charge_req;

    always_comb
    begin
        next_r = r;
        // bits 5, 6, 8, 9, 11 and above are simply never decoded
        cmd = decode_cmd(r.cmd_word);
        start_rise = cmd.start & ~r.start_q;
        enables_ok = enables_of(cmd);
        start_req = start_request(i_start_mode, cmd, r.edge_armed);
        run_ok = start_req & enables_ok & ~i_fault_active;
        charge_req = i_app_precharge ? cmd.precharge : 1'b1;

        // accept word only when valid, else hold previous
        if (i_cmd_write &&
            i_fieldbus_command_word[fcws_pkg::BIT_DATA_VALID])
        begin
            next_r.cmd_word = i_fieldbus_command_word;
        end

        next_r.start_q = cmd.start;
        next_r.reset_q = cmd.event_reset;
        next_r.fault_reset_req = cmd.event_reset & ~r.reset_q;
        next_r.quick_stop_evt = 1'b0;

        // fresh edge arms; refused edge, low bit or fault disarms
        if (!cmd.start || i_fault_active)
        begin
            next_r.edge_armed = 1'b0;
        end
        else if (start_rise)
        begin
            next_r.edge_armed = enables_ok;
        end

        if (i_fieldbus_active)
        begin
            case (r.state)
                fcws_pkg::ST_OFF:
                begin
                    if (ready_allowed(cmd, i_fault_active, i_inhibit))
                    begin
                        next_r.state = fcws_pkg::ST_READY;
                    end
                end
                fcws_pkg::ST_READY:
                begin
                    next_r.charging = charge_next(cmd, start_rise,
                        charge_req, r.charging);
                    if (!cmd.breaker_en || i_fault_active || i_inhibit)
                    begin
                        next_r.state = fcws_pkg::ST_OFF;
                    end
                    else if (r.charging && next_r.charging && i_charge_done)
                    begin
                        next_r.state = fcws_pkg::ST_SWITCHED_ON;
                    end
                end
                fcws_pkg::ST_SWITCHED_ON:
                begin
                    if (drop_to_off(cmd, i_fault_active))
                    begin
                        next_r.state = fcws_pkg::ST_OFF;
                    end
                    else if (step_down(cmd))
                    begin
                        next_r.state = step_back(r.state);
                    end
                    else if (run_ok && cmd.qstop_n)
                    begin
                        next_r.state = fcws_pkg::ST_OPERATING;
                    end
                end
                fcws_pkg::ST_OPERATING:
                begin
                    if (drop_to_off(cmd, i_fault_active))
                    begin
                        next_r.state = fcws_pkg::ST_OFF;
                    end
                    else if (step_down(cmd))
                    begin
                        next_r.state = step_back(r.state);
                    end
                    else if (!cmd.qstop_n)
                    begin
                        next_r.state = fcws_pkg::ST_SWITCHED_ON;
                        next_r.quick_stop_evt = 1'b1;
                    end
                end
                default:
                begin
                    next_r.state = fcws_pkg::ST_OFF;
                end
            endcase
        end

        if (!state_is(next_r.state, fcws_pkg::ST_READY))
        begin
            next_r.charging = 1'b0;
        end
        next_r.breaker_close = breaker_next(cmd, next_r.state,
            i_main_breaker_own, r.breaker_close);
        next_r.modulate = state_is(next_r.state, fcws_pkg::ST_OPERATING);

        // status word every cycle, whichever place is in control
        next_r.status_word = status_of(next_r.state, cmd.qstop_n,
            i_fault_active, next_r.charging, i_main_breaker_closed,
            i_fieldbus_active);
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_sys_rst)
        begin
            r <= '0;
            r.state <= fcws_pkg::ST_OFF;
            r.cmd_word <= fcws_pkg::CMD_RESET;
            r.status_word <= fcws_pkg::STATUS_RESET;
        end
        else if (i_clk_en)
        begin
            r <= next_r;
        end
    end

    assign o_status_word = r.status_word;
    assign o_state = r.state;
    assign o_charging = r.charging;
    assign o_main_breaker_close = r.breaker_close;
    assign o_modulate = r.modulate;
    assign o_fault_reset_req = r.fault_reset_req;
    assign o_quick_stop_evt = r.quick_stop_evt;

endmodule

// [test/fcws_master.sv]
// fcws_master: fieldbus master writing one command word per request
// assumes: request is a one-cycle pulse from the bench
`timescale 1ns/10ps
module fcws_master (
    input wire logic i_sys_clk,
    input wire logic i_req,
    input wire logic [15:0] i_word,
    output logic o_cmd_write,
    output logic [15:0] o_word
);
    always @(posedge i_sys_clk)
    begin
        o_cmd_write <= i_req;
        // reserved bit 5 cleared; idle word toggles
        o_word <= i_req ? (i_word & 16'hFFDF) : ~o_word;
    end
endmodule

// [test/fcws_props.sv]
// fcws_props: port assertions for fcws_sequencer
// assumes: bound to the sequencer, one clock, sync reset
`timescale 1ns/10ps
module fcws_props (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clk_en,
    input wire logic i_fieldbus_active,
    input wire logic [15:0] o_status_word,
    input wire logic [3:0] o_state,
    input wire logic o_modulate,
    input wire logic o_fault_reset_req,
    input wire logic o_quick_stop_evt
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_off_idle;
        o_state == 4'h1 && !i_fieldbus_active;
    endsequence
    sequence s_pulse;
        o_fault_reset_req ##1 !o_fault_reset_req;
    endsequence
    chk_state_onehot: assert property ($onehot(o_state))
        else $error("state not one-hot");
    chk_reset_value: assert property ($fell(i_sys_rst) |->
        o_state == 4'h1 && o_status_word == 16'h0001)
        else $error("bad state after reset");
    chk_status_mirror: assert property (o_status_word[3:0] == o_state)
        else $error("status word stale");
    chk_modulate_op: assert property (o_modulate == (o_state == 4'h8))
        else $error("modulate not tied to operating");
    chk_event_pulse: assert property (o_fault_reset_req && i_clk_en |->
        s_pulse)
        else $error("reset request not one cycle");
    chk_qstop_leave: assert property (o_quick_stop_evt && i_clk_en |=>
        !o_quick_stop_evt && o_state != 4'h8)
        else $error("quick stop event wrong");
    chk_inactive_hold: assert property (s_off_idle |=> o_state == 4'h1)
        else $error("state moved while inactive");
    chk_no_skip_run: assert property (o_state == 4'h2 |=> o_state != 4'h8)
        else $error("ready jumped to operating");
    chk_off_exit: assert property (o_state == 4'h1 |=>
        (o_state inside {4'h1, 4'h2}))
        else $error("off left to wrong state");
    chk_freeze_en: assert property (!i_clk_en |=> $stable(o_state))
        else $error("state moved with clock enable low");
endmodule
bind fcws_sequencer fcws_props u_props (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
    .i_fieldbus_active(i_fieldbus_active), .o_status_word(o_status_word),
    .o_state(o_state), .o_modulate(o_modulate),
    .o_fault_reset_req(o_fault_reset_req),
    .o_quick_stop_evt(o_quick_stop_evt));

// [test/test_fieldbus_control_word_sequencer.sv]
// test_fieldbus_control_word_sequencer: self-checking bench
// assumes: fcws_sequencer, fcws_master and fcws_props compiled first
`timescale 1ns/10ps
module test_fieldbus_control_word_sequencer;
    typedef struct packed {
        logic [15:0] word;
        logic done;
        logic [3:0] state;
    } fcws_row_type;
    localparam fcws_row_type rows [10] = '{'{16'h0406, 1'b0, 4'h2},
        '{16'h040F, 1'b0, 4'h2}, '{16'h040F, 1'b1, 4'h8},
        '{16'h0407, 1'b1, 4'h2}, '{16'h040F, 1'b1, 4'h8},
        '{16'h040B, 1'b1, 4'h4}, '{16'h040F, 1'b1, 4'h8},
        '{16'h040E, 1'b1, 4'h2}, '{16'h040C, 1'b1, 4'h1},
        '{16'h000F, 1'b1, 4'h1}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b1;
    logic req = 1'b0;
    logic fb = 1'b0;
    logic mode = 1'b0;
    logic fault = 1'b0;
    logic done = 1'b0;
    logic brk = 1'b0;
    logic app = 1'b0;
    logic inh = 1'b0;
    logic [15:0] wd = 16'h0000;
    logic wr, chg, cls, fres;
    logic [15:0] cw, status;
    logic [3:0] st;
    int miscompares = 0;
    int checks_done = 0;
    int cnt;
    always #10 clk = ~clk;
    always @(posedge clk) brk <= cls;
    fcws_master u_master (.i_sys_clk(clk), .i_req(req), .i_word(wd),
        .o_cmd_write(wr), .o_word(cw));
    fcws_sequencer u_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_clk_en(en),
        .i_cmd_write(wr), .i_fieldbus_command_word(cw),
        .i_fieldbus_active(fb), .i_start_mode(mode), .i_app_precharge(app),
        .i_fault_active(fault), .i_inhibit(inh), .i_charge_done(done),
        .i_main_breaker_closed(brk), .i_main_breaker_own(1'b1),
        .o_status_word(status), .o_state(st), .o_charging(chg),
        .o_main_breaker_close(cls), .o_modulate(), .o_fault_reset_req(fres),
        .o_quick_stop_evt());
    task automatic wrap_up;
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [15:0] w);
        @(posedge clk);
        req <= 1'b1;
        wd <= w;
        @(posedge clk);
        req <= 1'b0;
        repeat (8) @(negedge clk);
    endtask
    initial
    begin
        #400us;
        miscompares++;
        wrap_up;
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(status, 16'h0001);
        send(16'h0406);
        chk(status, 16'h0001);
        @(posedge clk) fb <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk) done <= rows[i].done;
            send(rows[i].word);
            chk({12'h000, st}, {12'h000, rows[i].state});
        end
        @(posedge clk) en <= 1'b0;
        repeat (3) @(posedge clk);
        en <= 1'b1;
        cnt = 0;
        @(posedge clk);
        req <= 1'b1;
        wd <= 16'h0480;
        @(posedge clk);
        req <= 1'b0;
        repeat (10)
        begin
            @(negedge clk);
            cnt += int'(fres);
        end
        chk(16'(cnt), 16'h0001);
        @(posedge clk) mode <= 1'b1;
        send(16'h0406);
        @(posedge clk) fault <= 1'b1;
        send(16'h040F);
        @(posedge clk) fault <= 1'b0;
        send(16'h040E);
        send(16'h040F);
        chk({15'h0000, chg}, 16'h0000);
        chk({12'h000, st}, 16'h0002);
        send(16'h0407);
        send(16'h040F);
        chk({12'h000, st}, 16'h0008);
        chk({15'h0000, cls}, 16'h0001);
        @(posedge clk) mode <= 1'b0;
        send(16'h0406);
        send(16'h040D);
        chk({11'h000, chg, st}, 16'h0001);
        @(posedge clk) app <= 1'b1;
        done <= 1'b0;
        send(16'h0406);
        send(16'h040F);
        chk({15'h0000, chg}, 16'h0000);
        send(16'h0407);
        send(16'h041F);
        chk(status, 16'h0142);
        send(16'h040F);
        chk({15'h0000, chg}, 16'h0000);
        @(posedge clk) inh <= 1'b1;
        repeat (2) @(negedge clk);
        chk({12'h000, st}, 16'h0001);
        wrap_up;
    end
endmodule
